// ### hdl/media_pkg.sv
// Constants and types shared by the removable-media state logic
package media_pkg;

  // Command codes presented on the command strobe
  typedef enum logic [3:0] {
    CMD_NONE        = 4'h0,
    CMD_NOTIFY_ON   = 4'h1,
    CMD_NOTIFY_OFF  = 4'h2,
    CMD_GET_STATUS  = 4'h3,
    CMD_LOCK        = 4'h4,
    CMD_UNLOCK      = 4'h5,
    CMD_EJECT       = 4'h6,
    CMD_DIAGNOSTIC  = 4'h7,
    CMD_DEVICE_RST  = 4'h8
  } media_cmd_t;

  // Bit positions of the media status byte
  localparam int unsigned STAT_WP_BIT  = 6;
  localparam int unsigned STAT_MC_BIT  = 5;
  localparam int unsigned STAT_MCR_BIT = 3;
  localparam int unsigned STAT_NM_BIT  = 1;

  // Bit positions of the notify-enable answer byte
  localparam int unsigned CAP_ENABLED_BIT = 0;
  localparam int unsigned CAP_LOCK_BIT    = 1;
  localparam int unsigned CAP_PEJECT_BIT  = 2;

  // Reset values of the state flags
  localparam logic FLAG_RESET = 1'b0;

  // Length of the eject pulse to the mechanism, in cycles
  localparam int unsigned EJECT_PULSE_CYCLES = 4;

endpackage : media_pkg

// ### hdl/input_sync.sv
// Two-flop synchroniser for pin-level inputs
module input_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Asynchronous input and synchronised output
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stage1 <= '0;
      sync_o <= '0;
    end
    else
    begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule // input_sync

// ### hdl/removable_media_lock_status.sv
// Notification, lock and media flag state of a removable-media device
module removable_media_lock_status
  import media_pkg::*;
#(
  parameter bit PACKET_SUPPORT = 1'b0,
  parameter bit CAN_LOCK       = 1'b1,
  parameter bit CAN_POWER_EJECT = 1'b1
) (
  // Clock and power-on reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Other reset sources, one-cycle pulses on clk_i
  input  wire logic             hard_reset_i,
  input  wire logic             soft_reset_i,
  // Command strobe from the task-file decoder
  input  wire logic             cmd_valid_i,
  input  media_pkg::media_cmd_t cmd_i,
  input  wire logic             start_stop_eject_i,
  // Drive pins, asynchronous
  input  wire logic             eject_button_i,
  input  wire logic             medium_present_i,
  input  wire logic             write_protect_i,
  // Command completion
  output logic                  done_o,
  output logic                  aborted_o,
  output logic [7:0]            status_byte_o,
  output logic [7:0]            cyl_high_o,
  // Mechanism and state
  output logic                  eject_o,
  output logic                  notify_mode_o,
  output logic                  lock_state_o
);

  import media_pkg::*;

  localparam logic [2:0] EJ_LAST = 3'(EJECT_PULSE_CYCLES - 1);

  logic [2:0] pin_sync;
  logic       button_s;
  logic       present_s;
  logic       wp_s;
  logic       button_d;
  logic       present_d;
  logic       button_press;
  logic       inserted;
  logic       notify_mode;
  logic       lock_state;
  logic       medium_changed_flag;
  logic       change_request_flag;
  logic       no_medium_flag;
  logic       full_reset;
  logic       eject_req;
  logic [2:0] eject_cnt;
  logic       is_cmd;
  logic       lock_mode;

  input_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i ({eject_button_i, medium_present_i, write_protect_i}),
    .sync_o  (pin_sync)
  );

  assign button_s  = pin_sync[2];
  assign present_s = pin_sync[1];
  assign wp_s      = pin_sync[0];

  // Reset conditions that end notification mode and clear lock
  assign full_reset = hard_reset_i | soft_reset_i
                    | (cmd_valid_i & (cmd_i == CMD_DIAGNOSTIC))
                    | (cmd_valid_i & (cmd_i == CMD_DEVICE_RST));
  assign is_cmd     = cmd_valid_i & ~full_reset;
  assign lock_mode  = ~notify_mode & ~PACKET_SUPPORT;

  // Edge detect on the synchronised pins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      button_d  <= 1'b0;
      present_d <= 1'b0;
    end
    else
    begin
      button_d  <= button_s;
      present_d <= present_s;
    end
  end

  assign button_press = button_s & ~button_d;
  assign inserted     = present_s & ~present_d;

  // Notification mode, one flag for both securing modes
  always_ff @(posedge clk_i)
  begin
    if (rst_i || full_reset)
      notify_mode <= FLAG_RESET;
    else if (is_cmd && cmd_i == CMD_NOTIFY_ON)
      notify_mode <= 1'b1;
    else if (is_cmd && cmd_i == CMD_NOTIFY_OFF)
      notify_mode <= 1'b0;
  end

  // Lock state, moved only in lock mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i || full_reset)
      lock_state <= FLAG_RESET;
    else if (is_cmd && cmd_i == CMD_NOTIFY_ON)
      lock_state <= 1'b0;
    else if (is_cmd && lock_mode && CAN_LOCK)
    begin
      if (cmd_i == CMD_LOCK && present_s)
        lock_state <= 1'b1;
      else if (cmd_i == CMD_UNLOCK || cmd_i == CMD_EJECT)
        lock_state <= 1'b0;
    end
  end

  // Change-request flag: button press while held, set beats clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i || full_reset)
      change_request_flag <= FLAG_RESET;
    else if (button_press && (notify_mode || lock_state))
      change_request_flag <= 1'b1;
    else if (is_cmd && (cmd_i == CMD_GET_STATUS || cmd_i == CMD_LOCK
                        || cmd_i == CMD_UNLOCK))
      change_request_flag <= 1'b0;
  end

  // Medium-changed flag: cleared by power-on and hard reset, and by the other resets only in notification mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i || hard_reset_i)
      medium_changed_flag <= FLAG_RESET;
    else if (full_reset && notify_mode)
      medium_changed_flag <= FLAG_RESET;
    else if (inserted)
      medium_changed_flag <= 1'b1;
    else if (is_cmd)
      medium_changed_flag <= 1'b0;
  end

  // No-medium flag follows the drive
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      no_medium_flag <= FLAG_RESET;
    else
      no_medium_flag <= ~present_s;
  end

  // Eject request: command or unguarded button press
  always_comb
  begin
    eject_req = 1'b0;
    if (is_cmd && cmd_i == CMD_EJECT && !PACKET_SUPPORT)
      eject_req = CAN_POWER_EJECT;
    else if (PACKET_SUPPORT && start_stop_eject_i && !full_reset)
      eject_req = CAN_POWER_EJECT;
    else if (button_press && !notify_mode && !lock_state)
      eject_req = 1'b1;
  end

  // Eject pulse generator
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      eject_o   <= 1'b0;
      eject_cnt <= 3'h0;
    end
    else if (eject_req && !eject_o)
    begin
      eject_o   <= 1'b1;
      eject_cnt <= 3'h0;
    end
    else if (eject_o)
    begin
      eject_o   <= (eject_cnt != EJ_LAST);
      eject_cnt <= eject_cnt + 3'h1;
    end
  end

  // Completion answers, one cycle after the command
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      done_o        <= 1'b0;
      aborted_o     <= 1'b0;
      status_byte_o <= 8'h00;
      cyl_high_o    <= 8'h00;
    end
    else
    begin
      done_o    <= cmd_valid_i;
      aborted_o <= is_cmd && PACKET_SUPPORT
                   && (cmd_i == CMD_LOCK || cmd_i == CMD_UNLOCK
                       || cmd_i == CMD_EJECT);
      status_byte_o <= 8'h00;
      cyl_high_o    <= 8'h00;
      if (is_cmd && (cmd_i == CMD_GET_STATUS || cmd_i == CMD_LOCK
                     || cmd_i == CMD_UNLOCK))
      begin
        status_byte_o[STAT_WP_BIT]  <= wp_s;
        status_byte_o[STAT_MC_BIT]  <= medium_changed_flag;
        status_byte_o[STAT_MCR_BIT] <= change_request_flag
                                       | (button_press
                                          & (notify_mode | lock_state));
        status_byte_o[STAT_NM_BIT]  <= no_medium_flag;
      end
      if (is_cmd && cmd_i == CMD_NOTIFY_ON)
      begin
        cyl_high_o[CAP_ENABLED_BIT] <= notify_mode;
        cyl_high_o[CAP_LOCK_BIT]    <= CAN_LOCK;
        cyl_high_o[CAP_PEJECT_BIT]  <= CAN_POWER_EJECT;
      end
    end
  end

  assign notify_mode_o = notify_mode;
  assign lock_state_o  = lock_state;

  // Checks
  a_one_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    !(notify_mode && lock_state))
    else $error("Notification and lock both active");
  a_notify_on: assert property (@(posedge clk_i) disable iff (rst_i)
    is_cmd && cmd_i == CMD_NOTIFY_ON |=> notify_mode)
    else $error("Notify enable not taken");
  a_lock_noop: assert property (@(posedge clk_i) disable iff (rst_i)
    notify_mode && is_cmd && (cmd_i == CMD_LOCK || cmd_i == CMD_UNLOCK)
    |=> !lock_state)
    else $error("Lock moved in notification mode");
  a_button_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    (notify_mode || lock_state) && !cmd_valid_i && !start_stop_eject_i
    && !eject_o |=> !eject_o)
    else $error("Button ejected a held medium");
  a_reset_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    full_reset |=> !notify_mode && !lock_state
    && !change_request_flag)
    else $error("Reset left state set");
  a_soft_keeps_mc: assert property (@(posedge clk_i) disable iff (rst_i)
    soft_reset_i && !notify_mode && !hard_reset_i && !inserted
    && medium_changed_flag |=> medium_changed_flag)
    else $error("Soft reset lost changed flag");
  a_cap_report: assert property (@(posedge clk_i) disable iff (rst_i)
    is_cmd && cmd_i == CMD_NOTIFY_ON |=>
    cyl_high_o[CAP_ENABLED_BIT] == $past(notify_mode))
    else $error("Prior notify state misreported");
  a_status_nm: assert property (@(posedge clk_i) disable iff (rst_i)
    is_cmd && cmd_i == CMD_GET_STATUS && no_medium_flag |=>
    done_o && status_byte_o[STAT_NM_BIT])
    else $error("No-medium not reported");
  a_eject_len: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(eject_o) |-> eject_o [*4] ##1 !eject_o)
    else $error("Eject pulse length wrong");
  a_mc_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    full_reset && notify_mode |=> !medium_changed_flag)
    else $error("Notify reset kept changed flag");
  a_unlock_free: assert property (@(posedge clk_i) disable iff (rst_i)
    is_cmd && lock_mode && cmd_i == CMD_UNLOCK |=> !lock_state)
    else $error("Unlock left medium locked");
  a_request_set: assert property (@(posedge clk_i) disable iff (rst_i)
    button_press && (notify_mode || lock_state) && !full_reset
    |=> change_request_flag)
    else $error("Held button press not flagged");

  c_notify: cover property (@(posedge clk_i) disable iff (rst_i)
    is_cmd && cmd_i == CMD_NOTIFY_ON ##1 notify_mode);
  c_locked: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(lock_state));
  c_eject: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(eject_o));
  c_request: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(change_request_flag));
  c_notify_reset: cover property (@(posedge clk_i) disable iff (rst_i)
    full_reset && notify_mode);

endmodule // removable_media_lock_status

// ### verif/media_drive_model.sv
// Drive mechanism model: medium slot, protect tab and eject motor
module media_drive_model (
  // Clock
  input  wire logic clk_i,
  // Bench controls
  input  wire logic insert_i,
  input  wire logic protect_i,
  // Eject motor from the device
  input  wire logic eject_i,
  // Pin levels seen by the device
  output logic      medium_present_o = 1'b0,
  output logic      write_protect_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Medium leaves on a motor pulse and arrives on an insert request
  always @(posedge clk_i)
  begin
    if (eject_i)
      medium_present_o <= 1'b0;
    else if (insert_i)
      medium_present_o <= 1'b1;
  end

  // Protect tab follows the bench level
  assign write_protect_o = protect_i;
endmodule // media_drive_model

// ### verif/removable_media_lock_status_test.sv
// Command sequences against the removable-media state logic
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin \
  err_count++; $display("unexpected %s exp %0h got %0h", n, e, s); \
  end end
module removable_media_lock_status_test
  import media_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk_i = 1'b0, rst_i = 1'b1, hard_reset_i = 1'b0;
  logic       soft_reset_i = 1'b0, cmd_valid_i = 1'b0, ins = 1'b0;
  logic       eject_button_i = 1'b0, prot = 1'b0;
  media_cmd_t cmd_i = CMD_NONE;
  logic       medium_present_i, write_protect_i, done_o, aborted_o;
  logic       eject_o, notify_mode_o, lock_state_o;
  logic [7:0] status_byte_o, cyl_high_o;
  int         err_count = 0, tests_run = 0, n;

  removable_media_lock_status dut (.clk_i(clk_i), .rst_i(rst_i),
    .hard_reset_i(hard_reset_i), .soft_reset_i(soft_reset_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .start_stop_eject_i(1'b0),
    .eject_button_i(eject_button_i), .medium_present_i(medium_present_i),
    .write_protect_i(write_protect_i), .done_o(done_o),
    .aborted_o(aborted_o), .status_byte_o(status_byte_o),
    .cyl_high_o(cyl_high_o), .eject_o(eject_o),
    .notify_mode_o(notify_mode_o), .lock_state_o(lock_state_o));

  media_drive_model drive (.clk_i(clk_i), .insert_i(ins),
    .protect_i(prot), .eject_i(eject_o),
    .medium_present_o(medium_present_i), .write_protect_o(write_protect_i));

  // Clock at 100 MHz
  initial forever #5 clk_i = ~clk_i;

  // Issue one command and check its completion pulse
  task automatic cmd(input media_cmd_t c);
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i <= c;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    #1;
    `CHK("done", 1'b1, done_o)
    `CHK("aborted", 1'b0, aborted_o)
  endtask

  // Command followed by a status byte compare
  task automatic st(input media_cmd_t c, input logic [7:0] e);
    cmd(c);
    `CHK("status", e, status_byte_o)
  endtask

  // Count eject cycles from the completion cycle on
  task automatic eject_len();
    n = 0;
    repeat (8)
    begin
      n += (eject_o === 1'b1);
      @(posedge clk_i);
      #1;
    end
  endtask

  // Press the eject button briefly and count motor cycles
  task automatic press();
    n = 0;
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk_i);
      eject_button_i <= (i < 3);
      #1;
      n += (eject_o === 1'b1);
    end
  endtask

  // Insert a medium and let the pin synchronisers settle
  task automatic insert();
    @(posedge clk_i);
    ins <= 1'b1;
    @(posedge clk_i);
    ins <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask

  // One-cycle hardware or software reset pulse
  task automatic pulse(input bit hard);
    @(posedge clk_i);
    if (hard) hard_reset_i <= 1'b1; else soft_reset_i <= 1'b1;
    @(posedge clk_i);
    hard_reset_i <= 1'b0;
    soft_reset_i <= 1'b0;
    #1;
  endtask

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog for a hung run
  initial
  begin
    #50us;
    err_count++;
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    `CHK("notify", 1'b0, notify_mode_o)
    insert();
    st(CMD_GET_STATUS, 8'h20);
    st(CMD_GET_STATUS, 8'h00);
    prot <= 1'b1;
    repeat (4) @(posedge clk_i);
    st(CMD_GET_STATUS, 8'h40);
    prot <= 1'b0;
    repeat (4) @(posedge clk_i);
    st(CMD_LOCK, 8'h00);
    `CHK("lock", 1'b1, lock_state_o)
    press();
    `CHK("eject", 0, n)
    st(CMD_UNLOCK, 8'h08);
    `CHK("lock", 1'b0, lock_state_o)
    press();
    `CHK("eject", 4, n)
    st(CMD_LOCK, 8'h02);
    `CHK("lock", 1'b0, lock_state_o)
    insert();
    st(CMD_LOCK, 8'h20);
    cmd(CMD_EJECT);
    `CHK("lock", 1'b0, lock_state_o)
    eject_len();
    `CHK("eject", 4, n)
    insert();
    pulse(1'b0);
    st(CMD_GET_STATUS, 8'h20);
    st(CMD_LOCK, 8'h00);
    press();
    pulse(1'b0);
    `CHK("lock", 1'b0, lock_state_o)
    st(CMD_GET_STATUS, 8'h00);
    cmd(CMD_LOCK);
    press();
    pulse(1'b1);
    `CHK("lock", 1'b0, lock_state_o)
    st(CMD_GET_STATUS, 8'h00);
    cmd(CMD_LOCK);
    press();
    cmd(CMD_DIAGNOSTIC);
    `CHK("lock", 1'b0, lock_state_o)
    st(CMD_GET_STATUS, 8'h00);
    cmd(CMD_LOCK);
    cmd(CMD_NOTIFY_ON);
    `CHK("cyl", 8'h06, cyl_high_o)
    `CHK("lock", 1'b0, lock_state_o)
    `CHK("notify", 1'b1, notify_mode_o)
    cmd(CMD_NOTIFY_ON);
    `CHK("cyl", 8'h07, cyl_high_o)
    cmd(CMD_LOCK);
    `CHK("lock", 1'b0, lock_state_o)
    press();
    `CHK("eject", 0, n)
    st(CMD_GET_STATUS, 8'h08);
    cmd(CMD_EJECT);
    eject_len();
    `CHK("eject", 4, n)
    st(CMD_GET_STATUS, 8'h02);
    insert();
    `CHK("notify", 1'b1, notify_mode_o)
    st(CMD_GET_STATUS, 8'h20);
    cmd(CMD_NOTIFY_OFF);
    `CHK("notify", 1'b0, notify_mode_o)
    cmd(CMD_NOTIFY_ON);
    `CHK("cyl", 8'h06, cyl_high_o)
    cmd(CMD_EJECT);
    eject_len();
    `CHK("eject", 4, n)
    insert();
    press();
    pulse(1'b0);
    `CHK("notify", 1'b0, notify_mode_o)
    st(CMD_GET_STATUS, 8'h00);
    cmd(CMD_NOTIFY_ON);
    pulse(1'b1);
    `CHK("notify", 1'b0, notify_mode_o)
    for (int i = 0; i < 2; i++)
    begin
      cmd(CMD_NOTIFY_ON);
      cmd((i != 0) ? CMD_DIAGNOSTIC : CMD_DEVICE_RST);
      `CHK("notify", 1'b0, notify_mode_o)
    end
    tally_and_finish();
  end
endmodule // removable_media_lock_status_test
